// File: hw/dpsp_pkg.sv
// types shared by the dual pot serial port
// assumes the constants header is included by the design file
package dpsp_pkg;

    // ****************************************
    // pin groups and states
    // ****************************************
    typedef struct packed {
        logic sck;
        logic cs_n;
        logic sdi;
    } dpsp_pins_t;

    typedef struct packed {
        logic o;
        logic oe;
    } dpsp_drive_t;

    typedef enum logic [0:0] {
        ST_IDLE,
        ST_SHIFT
    } dpsp_state_t;

endpackage

// File: hw/dpsp_port.sv
// serial register port of a dual digital potentiometer: two wiper registers, one
// access-control register, mode-0 slave shifter clocked by the system clock.
// assumes sck, cs_n and sdi are asynchronous pins; host sck well below clk/6.
`timescale 1ns/10ps
`include "dpsp_regs.svh"

// Contract
// - sdi bits are taken on sck rising edges only while selected.
// - sdo changes on chip-select and sck falling edges; host captures on the next rise.
// - access bit 1 picks sdo drive: 0 push-pull (default), 1 open-drain.
// - with chip select high, sdo floats and the port idles.
// - wiper value picks tap, 00h low end to 7Fh high end.
// - both wipers reset to 40h, mid scale.
// - wiper 0 at 0, wiper 1 at 1, access register at 10h.
// - access bit 6 low shuts pots down; resets high.
// - shutdown keeps wiper values; leaving it restores the stored taps.
// - slave only, spi clock mode 0.
// - every byte travels most significant bit first.
// - first byte is opcode in top three bits plus five address bits.
// - addresses 0 and 1 reach the wipers, 10000b the access register.
// - opcodes 000 nop, 001/011 access read/write, 100/110 addressed read/write.
// - writes take effect on the chip-select rising edge.
// - read frame returns echo in third byte, data in fourth.
// - shifted input pairs pass out on sdo toward the next chained device.
// - read response is 111b plus address, then the data byte.
module dpsp_port (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clk_en,
    // serial pins
    input wire logic sck,
    input wire logic cs_n,
    input wire logic sdi,
    output logic sdo_o,
    output logic sdo_oe,
    // potentiometer control
    output logic [7:0] wiper_zero_tap,
    output logic [7:0] wiper_one_tap,
    output logic power_down_n,
    output logic pots_open,
    output logic frame_active
);

    // ****************************************
    // helpers
    // ****************************************
    // register read mux, zero for unmapped addresses
    function automatic logic [7:0] reg_value(
        input logic [4:0] addr,
        input logic [7:0] w0,
        input logic [7:0] w1,
        input logic [7:0] acc
    );
        logic [7:0] v;
        v = 8'h00;
        case (addr)
            `DPSP_ADDR_WIPER0: v = w0;
            `DPSP_ADDR_WIPER1: v = w1;
            `DPSP_ADDR_ACCESS: v = acc;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // true when a pair writes the register at target
    function automatic logic wr_hit(
        input logic [15:0] pair,
        input logic [4:0] target
    );
        logic hit;
        hit = 1'b0;
        if (pair[15:13] == `DPSP_OP_REG_WR) begin
            hit = (pair[12:8] == target);
        end else if (pair[15:13] == `DPSP_OP_ACC_WR) begin
            hit = (target == `DPSP_ADDR_ACCESS);
        end
        return hit;
    endfunction

    // ****************************************
    // pin synchronisers
    // ****************************************
    dpsp_pkg::dpsp_pins_t s1_ff;
    dpsp_pkg::dpsp_pins_t s2_ff;
    dpsp_pkg::dpsp_pins_t s3_ff;
    dpsp_pkg::dpsp_pins_t filt_ff;
    dpsp_pkg::dpsp_pins_t nxt_filt;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_ff <= '0;
            s2_ff <= '0;
            s3_ff <= '0;
        end else if (clk_en) begin
            s1_ff <= '{sck: sck, cs_n: cs_n, sdi: sdi};
            s2_ff <= s1_ff;
            s3_ff <= s2_ff;
        end
    end

    // a level counts once stages two and three agree
    always_comb begin
        nxt_filt = filt_ff;
        if (s2_ff.sck == s3_ff.sck) begin
            nxt_filt.sck = s3_ff.sck;
        end
        if (s2_ff.cs_n == s3_ff.cs_n) begin
            nxt_filt.cs_n = s3_ff.cs_n;
        end
        if (s2_ff.sdi == s3_ff.sdi) begin
            nxt_filt.sdi = s3_ff.sdi;
        end
    end

    // chip select filters from low so a select held through reset is no edge
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            filt_ff <= '0;
        end else if (clk_en) begin
            filt_ff <= nxt_filt;
        end
    end

    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic cs_rise;
    assign sck_rise = ~filt_ff.sck & nxt_filt.sck;
    assign sck_fall = filt_ff.sck & ~nxt_filt.sck;
    assign cs_fall = filt_ff.cs_n & ~nxt_filt.cs_n;
    assign cs_rise = ~filt_ff.cs_n & nxt_filt.cs_n;

    // ****************************************
    // frame state
    // ****************************************
    dpsp_pkg::dpsp_state_t state_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_ff <= dpsp_pkg::ST_IDLE;
        end else if (clk_en) begin
            case (state_ff)
                dpsp_pkg::ST_IDLE: begin
                    if (cs_fall) begin
                        state_ff <= dpsp_pkg::ST_SHIFT;
                    end
                end
                dpsp_pkg::ST_SHIFT: begin
                    if (cs_rise) begin
                        state_ff <= dpsp_pkg::ST_IDLE;
                    end
                end
                default: state_ff <= dpsp_pkg::ST_IDLE;
            endcase
        end
    end

    logic shifting;
    logic take_bit;
    assign shifting = (state_ff == dpsp_pkg::ST_SHIFT) && !cs_rise;
    assign take_bit = shifting && sck_rise;

    // ****************************************
    // input shifter
    // ****************************************
    logic [14:0] in_sr_ff;
    logic [3:0] bit_cnt_ff;
    logic [15:0] pair_ff;
    logic pair_vld_ff;
    logic [15:0] nxt_pair;
    logic pair_done;
    assign nxt_pair = {in_sr_ff, nxt_filt.sdi};
    assign pair_done = take_bit && (bit_cnt_ff == `DPSP_PAIR_LAST);

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            in_sr_ff <= '0;
            bit_cnt_ff <= '0;
        end else if (clk_en) begin
            if (cs_fall || cs_rise) begin
                bit_cnt_ff <= '0;
            end else if (take_bit) begin
                in_sr_ff <= nxt_pair[14:0];
                bit_cnt_ff <= bit_cnt_ff + 4'h1;
            end
        end
    end

    // latest whole instruction and data pair of this frame
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pair_ff <= '0;
            pair_vld_ff <= 1'b0;
        end else if (clk_en) begin
            if (cs_fall) begin
                pair_vld_ff <= 1'b0;
            end else if (pair_done) begin
                pair_ff <= nxt_pair;
                pair_vld_ff <= 1'b1;
            end
        end
    end

    // ****************************************
    // registers
    // ****************************************
    logic [7:0] wiper0_ff;
    logic [7:0] wiper1_ff;
    logic [7:0] access_ff;
    logic apply;
    assign apply = (state_ff == dpsp_pkg::ST_SHIFT) && cs_rise && pair_vld_ff;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wiper0_ff <= `DPSP_WIPER_RST;
            wiper1_ff <= `DPSP_WIPER_RST;
        end else if (clk_en && apply) begin
            if (wr_hit(pair_ff, `DPSP_ADDR_WIPER0)) begin
                wiper0_ff <= pair_ff[7:0];
            end
            if (wr_hit(pair_ff, `DPSP_ADDR_WIPER1)) begin
                wiper1_ff <= pair_ff[7:0];
            end
        end
    end

    // only the shutdown and drive-type bits are writable
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            access_ff <= `DPSP_ACCESS_RST;
        end else if (clk_en && apply && wr_hit(pair_ff, `DPSP_ADDR_ACCESS)) begin
            access_ff <= pair_ff[7:0] & `DPSP_ACC_WR_MASK;
        end
    end

    // ****************************************
    // response and chain output
    // ****************************************
    logic [15:0] out_sr_ff;
    logic sdo_bit_ff;
    logic [15:0] nxt_out;
    logic [4:0] rd_addr;
    logic is_read;

    always_comb begin
        rd_addr = nxt_pair[12:8];
        is_read = 1'b0;
        case (nxt_pair[15:13])
            `DPSP_OP_ACC_RD: begin
                rd_addr = `DPSP_ADDR_ACCESS;
                is_read = 1'b1;
            end
            `DPSP_OP_REG_RD: begin
                is_read = 1'b1;
            end
            default: is_read = 1'b0;
        endcase
        if (is_read) begin
            nxt_out = {`DPSP_ECHO_CODE, rd_addr,
                       reg_value(rd_addr, wiper0_ff, wiper1_ff, access_ff)};
        end else begin
            nxt_out = nxt_pair;
        end
    end

    // the word survives chip-select rise so a chained read answers next frame
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            out_sr_ff <= '0;
            sdo_bit_ff <= 1'b0;
        end else if (clk_en) begin
            if (pair_done) begin
                out_sr_ff <= nxt_out;
            end else if (cs_fall || (shifting && sck_fall)) begin
                sdo_bit_ff <= out_sr_ff[15];
                out_sr_ff <= {out_sr_ff[14:0], 1'b0};
            end
        end
    end

    // ****************************************
    // pin drive and outputs
    // ****************************************
    dpsp_pkg::dpsp_drive_t drive_ff;
    logic odrain;
    assign odrain = access_ff[`DPSP_ACC_ODRAIN_BIT];

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            drive_ff <= '0;
        end else if (clk_en) begin
            if (state_ff != dpsp_pkg::ST_SHIFT) begin
                drive_ff <= '0;
            end else if (odrain) begin
                drive_ff <= '{o: 1'b0, oe: ~sdo_bit_ff};
            end else begin
                drive_ff <= '{o: sdo_bit_ff, oe: 1'b1};
            end
        end
    end

    logic pots_open_ff;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pots_open_ff <= 1'b0;
        end else if (clk_en) begin
            pots_open_ff <= ~access_ff[`DPSP_ACC_PDN_BIT];
        end
    end

    assign sdo_o = drive_ff.o;
    assign sdo_oe = drive_ff.oe;
    // taps stay stored through shutdown; pots_open alone disconnects the array
    assign wiper_zero_tap = wiper0_ff;
    assign wiper_one_tap = wiper1_ff;
    assign power_down_n = access_ff[`DPSP_ACC_PDN_BIT];
    assign pots_open = pots_open_ff;
    assign frame_active = (state_ff == dpsp_pkg::ST_SHIFT);

endmodule // dpsp_port

// File: hw/dpsp_regs.svh
// register offsets, field positions, reset values and codes of the dual pot port
// assumes nothing; definitions only
`ifndef DPSP_REGS_SVH
`define DPSP_REGS_SVH

// ****************************************
// register addresses
// ****************************************
`define DPSP_ADDR_WIPER0 5'h00
`define DPSP_ADDR_WIPER1 5'h01
`define DPSP_ADDR_ACCESS 5'h10

// ****************************************
// reset values and fields
// ****************************************
`define DPSP_WIPER_RST 8'h40
`define DPSP_ACCESS_RST 8'h40
`define DPSP_ACC_PDN_BIT 6
`define DPSP_ACC_ODRAIN_BIT 1
`define DPSP_ACC_WR_MASK 8'h42

// ****************************************
// opcodes and framing
// ****************************************
`define DPSP_OP_NOP 3'h0
`define DPSP_OP_ACC_RD 3'h1
`define DPSP_OP_ACC_WR 3'h3
`define DPSP_OP_REG_RD 3'h4
`define DPSP_OP_REG_WR 3'h6
`define DPSP_ECHO_CODE 3'h7
`define DPSP_PAIR_LAST 4'hf

`endif

// File: verification/dpsp_host_model.sv
// spi host for the dual pot port: mode 0, msb first, sck period 25 clks
// assumes sdo_line is already resolved against its pull-up
`timescale 1ns/10ps
module dpsp_host_model (
    // clock
    input wire logic clk,
    // spi pins
    output logic sck,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo_line
);
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // ****************
    // one framed exchange of n bits
    // ****************
    task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = '0;
        @(posedge clk) cs_n <= 1'b0;
        repeat (60) @(posedge clk);
        for (int i = n - 1; i >= 0; i--) begin
            sdi <= tx[i];
            repeat (13) @(posedge clk);
            sck <= 1'b1;
            rx = {rx[30:0], sdo_line};
            repeat (12) @(posedge clk);
            sck <= 1'b0;
        end
        repeat (60) @(posedge clk);
        cs_n <= 1'b1;
        // the host lets go of sdi between frames: show it wandering
        sdi <= ~sdi;
        repeat (60) @(posedge clk);
    endtask
endmodule // dpsp_host_model

// File: verification/dpsp_port_assertions.sv
// pin-level checks of the dual pot serial port
// assumes clk_en high and chip select high at least 8 clks between frames
`timescale 1ns/10ps
module dpsp_port_assertions (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // serial pins
    input wire logic sck,
    input wire logic cs_n,
    input wire logic sdo_o,
    input wire logic sdo_oe,
    // pot control
    input wire logic [7:0] wiper_zero_tap,
    input wire logic [7:0] wiper_one_tap,
    input wire logic power_down_n,
    input wire logic pots_open,
    input wire logic frame_active
);
    default clocking dpsp_cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    // ****************
    // pin rules
    // ****************
    idle_float_a: assert property (cs_n [*8] |-> !sdo_oe && !frame_active)
        else $error("port active while deselected");
    frame_start_a: assert property ($rose(frame_active) |-> !cs_n && !$past(cs_n, 2))
        else $error("frame began without select");
    oe_release_a: assert property ($fell(frame_active) |-> ##[0:2] !sdo_oe)
        else $error("sdo driven after frame");
    // sdo moves only after sck falls or chip select changes, so a long high phase sees it still
    sdo_hold_a: assert property (sck [*8] |-> $stable(sdo_o) && $stable(sdo_oe))
        else $error("sdo moved while sck high");
    shut_open_a: assert property (!power_down_n [*2] |-> pots_open)
        else $error("pots not open in shutdown");
    run_closed_a: assert property (power_down_n [*2] |-> !pots_open)
        else $error("pots open while running");
    wiper_zero_apply_a: assert property ($changed(wiper_zero_tap) |-> cs_n)
        else $error("wiper 0 changed in frame");
    wiper_one_apply_a: assert property ($changed(wiper_one_tap) |-> cs_n)
        else $error("wiper 1 changed in frame");
    acc_apply_a: assert property ($changed(power_down_n) |-> cs_n)
        else $error("shutdown changed in frame");
    cover property ($rose(pots_open));
    cover property ($changed(wiper_one_tap));
    cover property (sdo_oe && !sdo_o);
endmodule // dpsp_port_assertions

bind dpsp_port dpsp_port_assertions i_chk (.clk(clk), .rst_n(rst_n), .sck(sck), .cs_n(cs_n),
    .sdo_o(sdo_o), .sdo_oe(sdo_oe), .wiper_zero_tap(wiper_zero_tap),
    .wiper_one_tap(wiper_one_tap), .power_down_n(power_down_n), .pots_open(pots_open),
    .frame_active(frame_active));

// File: verification/tb_dual_pot_spi_register_port.sv
// self-checking bench of the dual pot serial port
// assumes the host model drives the spi pins and sdo has a pull-up
`timescale 1ns/10ps
module tb_dual_pot_spi_register_port;
    typedef struct packed {
        logic [15:0] wr;
        logic [7:0] rd;
        logic [7:0] exp;
        logic pd;
    } dpsp_row_t;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    wire sck, cs_n, sdi;
    logic sdo_o, sdo_oe, pdn, popen, fa;
    logic [7:0] w0, w1;
    logic [15:0] ev;
    logic [31:0] rx;
    // open-drain needs the board pull-up; a floating push-pull reads high too
    wire sdo_line = sdo_oe ? sdo_o : 1'b1;
    int errors = 0;
    int cmp_count = 0;
    int hi_cnt = 0;
    int hi_mark = 0;
    // write pair, read instruction, value read back, power_down_n after
    dpsp_row_t rows [8] = '{
        '{16'hc07f, 8'h80, 8'h7f, 1'b1},
        '{16'hc100, 8'h81, 8'h00, 1'b1},
        '{16'h6bff, 8'h2b, 8'h42, 1'b1},
        '{16'hd000, 8'h90, 8'h00, 1'b0},
        '{16'hc255, 8'h80, 8'h7f, 1'b0},
        '{16'h4011, 8'h80, 8'h7f, 1'b0},
        '{16'h7040, 8'h30, 8'h40, 1'b1},
        '{16'h0000, 8'h85, 8'h00, 1'b1}
    };

    always #2.5 clk = ~clk;

    // cycles in which sdo actively drives a one; open drain must never do so
    always @(posedge clk) begin
        if (sdo_oe && sdo_o) begin
            hi_cnt <= hi_cnt + 1;
        end
    end

    dpsp_port i_dut (
        .clk(clk), .rst_n(rst_n), .clk_en(1'b1), .sck(sck), .cs_n(cs_n), .sdi(sdi),
        .sdo_o(sdo_o), .sdo_oe(sdo_oe), .wiper_zero_tap(w0), .wiper_one_tap(w1),
        .power_down_n(pdn), .pots_open(popen), .frame_active(fa)
    );
    dpsp_host_model i_host (.clk(clk), .sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo_line(sdo_line));

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] want);
        cmp_count++;
        if (seen !== want) begin
            errors++;
            $display("BAD %s exp %h got %h", what, want, seen);
        end
    endtask

    task automatic wrap_up();
        $display("compares %0d mismatches %0d", cmp_count, errors);
        if (errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    initial begin
        repeat (90000) @(posedge clk);
        errors++;
        wrap_up();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        check("reset", 32'({w0, w1, pdn, popen, sdo_oe, fa}), 32'h40408);
        $display("reset test done");
        foreach (rows[i]) begin
            i_host.frame(32'(rows[i].wr), 16, rx);
            i_host.frame({rows[i].rd, 24'h0}, 32, rx);
            ev = {3'h7, (rows[i].rd[7:5] == 3'h1) ? 5'h10 : rows[i].rd[4:0], rows[i].exp};
            check("read back", 32'(rx[15:0]), 32'(ev));
            check("shutdown", 32'({pdn, popen}), 32'({rows[i].pd, !rows[i].pd}));
            $display("row %0d done", i);
        end
        check("taps", 32'({w0, w1}), 32'h7f00);
        i_host.frame(32'hc05, 12, rx);
        check("partial pair", 32'(w0), 32'h7f);
        i_host.frame(32'hc133aa, 24, rx);
        check("odd byte", 32'(w1), 32'h33);
        $display("partial frame test done");
        i_host.frame(32'hc0120000, 32, rx);
        check("pass through", 32'(rx[15:0]), 32'hc012);
        check("last pair", 32'(w0), 32'h7f);
        $display("chain test done");
        i_host.frame(32'h6042, 16, rx);
        hi_mark = hi_cnt;
        i_host.frame(32'h20000000, 32, rx);
        check("open drain read", 32'(rx[15:0]), 32'hf042);
        check("open drain high", 32'(hi_cnt - hi_mark), 32'h0);
        i_host.frame(32'h6040, 16, rx);
        hi_mark = hi_cnt;
        i_host.frame(32'h20000000, 32, rx);
        check("push pull high", 32'(hi_cnt > hi_mark), 32'h1);
        $display("drive type test done");
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        repeat (10) @(posedge clk);
        check("mid reset", 32'({w0, w1, pdn, popen, sdo_oe, fa}), 32'h40408);
        i_host.frame(32'h81000000, 32, rx);
        check("read after reset", 32'(rx[15:0]), 32'he140);
        $display("mid reset test done");
        wrap_up();
    end
endmodule // tb_dual_pot_spi_register_port
